/* design/pbmc_defines.svh */
// Constants of the transceiver basic mode control register bank.
// Assumes a 20 MHz mclk and an AXI4-Lite master with 32-bit data.
// Function
// - Clear-on-read field returns value, then clears
// - Latched-low field holds zero until read
// - Latched-high field holds one until read
// - Permanent read-only field ignores writes
// - Self-clearing field clears when event ends
// - Bit 15 starts reset, reads one meanwhile
// - Software reset reloads straps like power-on
// - Bit 14 loops MAC transmit to receive
// - Loopback entry may blank receive 500 us
// - Bit 13 selects speed, strap reset
// - Auto-negotiation enable resets from strap
// - Fiber mode resets auto-negotiation enable to zero
// - Auto-negotiation on ignores speed and duplex
// - Bit 11 powers down, registers stay alive
// - Power-down bit ORed with active-low pin
// - Bit 10 isolates MAC data, management works
// - Bit 8 selects duplex, strap reset
`ifndef PBMC_DEFINES_SVH
`define PBMC_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PBMC_ADDR_W          8
`define PBMC_OFF_CONTROL     8'h00
`define PBMC_OFF_STATUS      8'h04

// ****************************************************************
// Control field positions
// ****************************************************************
`define PBMC_BIT_RESET       15
`define PBMC_BIT_LOOPBACK    14
`define PBMC_BIT_SPEED       13
`define PBMC_BIT_AN_ENABLE   12
`define PBMC_BIT_POWER_DOWN  11
`define PBMC_BIT_ISOLATE     10
`define PBMC_BIT_DUPLEX      8

// ****************************************************************
// Status field positions
// ****************************************************************
`define PBMC_BIT_LINK_OK     0
`define PBMC_BIT_FAULT       1
`define PBMC_FIXED_LSB       4
`define PBMC_ERRCNT_LSB      8
// Arbitrary value, no meaning beyond a fixed pattern
`define PBMC_FIXED_CODE      4'h5

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define PBMC_ZERO16          16'h0000
`define PBMC_ZERO32          32'h0000_0000
`define PBMC_RESP_OKAY       2'h0
`define PBMC_RESP_SLVERR     2'h2
`define PBMC_SYNC_RST        5'h10

// ****************************************************************
// Timing
// ****************************************************************
`define PBMC_CLK_PERIOD_NS   50
`define PBMC_RESET_TIME_NS   1000
`define PBMC_RESET_CYCLES    ((`PBMC_RESET_TIME_NS + `PBMC_CLK_PERIOD_NS - 1) / `PBMC_CLK_PERIOD_NS)
`define PBMC_DEAD_TIME_US    500
`define PBMC_DEAD_CYCLES     ((`PBMC_DEAD_TIME_US * 1000) / `PBMC_CLK_PERIOD_NS)

`endif

/* design/pbmc_pkg.sv */
// Types shared by the basic mode control register bank.
// Assumes the constants header is compiled alongside.
package pbmc_pkg;

  // ****************************************************************
  // Reset sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RESET = 2'b01,
    ST_RUN   = 2'b10
  } pbmc_state_t;

endpackage

/* design/pbmc_sync.sv */
// Two-flop synchroniser for pin-level inputs, one stage pair per bit.
// Assumes inputs are asynchronous levels; pulses shorter than a cycle may be lost.
`timescale 1ns/10ps
module pbmc_sync #(
  parameter int unsigned         WIDTH   = 5,
  parameter logic [WIDTH-1:0]    RST_VAL = '0
)(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // Levels
  input  wire logic [WIDTH-1:0]  asyncIn,
  output logic      [WIDTH-1:0]  syncOut
);

  logic [WIDTH-1:0] stage1_r;

  // ****************************************************************
  // Per-bit stages
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gBit
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          stage1_r[i] <= RST_VAL[i];
          syncOut[i]  <= RST_VAL[i];
        end
        else
        begin
          stage1_r[i] <= asyncIn[i];
          syncOut[i]  <= stage1_r[i];
        end
      end
    end
  endgenerate

endmodule // pbmc_sync

/* design/pbmc_top.sv */
// Basic mode control register bank with AXI4-Lite access and MAC data gating.
// Assumes MAC and line data run on mclk; straps and power-down pin are asynchronous.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "pbmc_defines.svh"
module pbmc_top
  import pbmc_pkg::*;
#(
  parameter int unsigned DEAD_CYCLES = `PBMC_DEAD_CYCLES,
  parameter logic [3:0]  FIXED_CODE  = `PBMC_FIXED_CODE
)(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // AXI4-Lite write address and data
  input  wire logic [`PBMC_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`PBMC_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Straps and pins
  input  wire logic                     strapAnEnable,
  input  wire logic                     strapSpeed100,
  input  wire logic                     strapFullDuplex,
  input  wire logic                     fiberModeEnable,
  input  wire logic                     powerDownRequestPin_n,
  // Link events and negotiated result
  input  wire logic                     linkUp,
  input  wire logic                     faultEvent,
  input  wire logic                     rxErrorPulse,
  input  wire logic                     anSpeed100,
  input  wire logic                     anFullDuplex,
  // MAC side data
  input  wire logic [3:0]               macTxData,
  input  wire logic                     macTxEn,
  output logic [3:0]                    macRxData,
  output logic                          macRxDv,
  // Line side data
  output logic [3:0]                    lineTxData,
  output logic                          lineTxEn,
  input  wire logic [3:0]               lineRxData,
  input  wire logic                     lineRxDv,
  // Mode outputs
  output logic                          linkSpeed100,
  output logic                          linkFullDuplex,
  output logic                          powerDown
);

  localparam logic [4:0]  RESET_CNT = 5'(`PBMC_RESET_CYCLES);
  localparam logic [13:0] DEAD_CNT  = 14'(DEAD_CYCLES);

  pbmc_state_t          state_r;
  logic [4:0]           rstCnt_r;
  logic                 loopback_r;
  logic                 loopPrev_r;
  logic                 speed100_r;
  logic                 anEnable_r;
  logic                 powerDown_r;
  logic                 isolate_r;
  logic                 fullDuplex_r;
  logic [13:0]          deadCnt_r;
  logic                 linkOk_r;
  logic                 fault_r;
  logic [7:0]           errCnt_r;
  logic                 awTaken_r;
  logic                 wTaken_r;
  logic [`PBMC_ADDR_W-1:0] awAddr_r;
  logic [31:0]          wData_r;
  logic [3:0]           wStrb_r;
  logic [4:0]           pinSync;
  logic                 sStrapAn;
  logic                 sStrapSpeed;
  logic                 sStrapDuplex;
  logic                 sFiber;
  logic                 sPdPin_n;
  logic                 resetting;
  logic                 pdEffective;
  logic                 doWrite;
  logic                 writeControl;
  logic                 readTake;
  logic                 readStatus;
  logic                 quiet;
  logic [15:0]          controlView;
  logic [15:0]          statusView;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pbmc_sync #(
    .WIDTH   (5),
    .RST_VAL (`PBMC_SYNC_RST)
  ) uSync (
    .mclk    (mclk),
    .rstn    (rstn),
    .asyncIn ({powerDownRequestPin_n, fiberModeEnable, strapFullDuplex, strapSpeed100, strapAnEnable}),
    .syncOut (pinSync)
  );

  assign sStrapAn     = pinSync[0];
  assign sStrapSpeed  = pinSync[1];
  assign sStrapDuplex = pinSync[2];
  assign sFiber       = pinSync[3];
  assign sPdPin_n     = pinSync[4];

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  // Hardware and software reset share one sequence, so straps are sampled
  // only after the synchronisers have settled.
  assign resetting    = (state_r == ST_RESET);
  assign writeControl = doWrite && (awAddr_r == `PBMC_OFF_CONTROL) && wStrb_r[1];

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r  <= ST_RESET;
      rstCnt_r <= 5'h00;
    end
    else
    begin
      case (state_r)
        ST_RESET:
        begin
          if (rstCnt_r >= RESET_CNT - 5'h01)
          begin
            state_r  <= ST_RUN;
            rstCnt_r <= 5'h00;
          end
          else
          begin
            rstCnt_r <= rstCnt_r + 5'h01;
          end
        end
        ST_RUN:
        begin
          if (writeControl && wData_r[`PBMC_BIT_RESET])
          begin
            state_r  <= ST_RESET;
            rstCnt_r <= 5'h00;
          end
        end
        default:
        begin
          state_r  <= ST_RESET;
          rstCnt_r <= 5'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Control fields
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      loopback_r   <= 1'b0;
      speed100_r   <= 1'b0;
      anEnable_r   <= 1'b0;
      powerDown_r  <= 1'b0;
      isolate_r    <= 1'b0;
      fullDuplex_r <= 1'b0;
    end
    else if (resetting)
    begin
      loopback_r   <= 1'b0;
      speed100_r   <= sStrapSpeed;
      anEnable_r   <= sStrapAn && !sFiber;
      powerDown_r  <= 1'b0;
      isolate_r    <= 1'b0;
      fullDuplex_r <= sStrapDuplex;
    end
    else if (writeControl && !wData_r[`PBMC_BIT_RESET])
    begin
      loopback_r   <= wData_r[`PBMC_BIT_LOOPBACK];
      speed100_r   <= wData_r[`PBMC_BIT_SPEED];
      anEnable_r   <= wData_r[`PBMC_BIT_AN_ENABLE];
      powerDown_r  <= wData_r[`PBMC_BIT_POWER_DOWN];
      isolate_r    <= wData_r[`PBMC_BIT_ISOLATE];
      fullDuplex_r <= wData_r[`PBMC_BIT_DUPLEX];
    end
  end

  // ****************************************************************
  // Mode outputs
  // ****************************************************************
  assign pdEffective = powerDown_r || !sPdPin_n;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      linkSpeed100   <= 1'b0;
      linkFullDuplex <= 1'b0;
      powerDown      <= 1'b0;
    end
    else
    begin
      linkSpeed100   <= anEnable_r ? anSpeed100 : speed100_r;
      linkFullDuplex <= anEnable_r ? anFullDuplex : fullDuplex_r;
      powerDown      <= pdEffective;
    end
  end

  // ****************************************************************
  // Loopback dead time
  // ****************************************************************
  // Worst-case blanking is applied every time, trading latency for a
  // receive stream that never shows half-locked data.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      loopPrev_r <= 1'b0;
      deadCnt_r  <= 14'h0000;
    end
    else
    begin
      loopPrev_r <= loopback_r;
      if (loopback_r && !loopPrev_r)
      begin
        deadCnt_r <= DEAD_CNT;
      end
      else if (deadCnt_r != 14'h0000)
      begin
        deadCnt_r <= deadCnt_r - 14'h0001;
      end
    end
  end

  // ****************************************************************
  // MAC and line data paths
  // ****************************************************************
  // Only the management side stays alive while quiet.
  assign quiet = resetting || isolate_r || pdEffective;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      macRxData  <= 4'h0;
      macRxDv    <= 1'b0;
      lineTxData <= 4'h0;
      lineTxEn   <= 1'b0;
    end
    else if (quiet)
    begin
      macRxData  <= 4'h0;
      macRxDv    <= 1'b0;
      lineTxData <= 4'h0;
      lineTxEn   <= 1'b0;
    end
    else if (loopback_r)
    begin
      macRxData  <= macTxData;
      macRxDv    <= macTxEn && loopPrev_r && (deadCnt_r == 14'h0000);
      lineTxData <= 4'h0;
      lineTxEn   <= 1'b0;
    end
    else
    begin
      macRxData  <= lineRxData;
      macRxDv    <= lineRxDv;
      lineTxData <= macTxData;
      lineTxEn   <= macTxEn;
    end
  end

  // ****************************************************************
  // Status fields
  // ****************************************************************
  assign readTake   = s_axi_arvalid && s_axi_arready;
  assign readStatus = readTake && (s_axi_araddr == `PBMC_OFF_STATUS);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      linkOk_r <= 1'b0;
      fault_r  <= 1'b0;
      errCnt_r <= 8'h00;
    end
    else if (readStatus)
    begin
      linkOk_r <= linkUp;
      fault_r  <= faultEvent;
      errCnt_r <= {7'h00, rxErrorPulse};
    end
    else
    begin
      linkOk_r <= linkOk_r && linkUp;
      fault_r  <= fault_r || faultEvent;
      if (rxErrorPulse && (errCnt_r != 8'hFF))
      begin
        errCnt_r <= errCnt_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Register views
  // ****************************************************************
  always_comb
  begin
    controlView                       = `PBMC_ZERO16;
    controlView[`PBMC_BIT_RESET]      = resetting;
    controlView[`PBMC_BIT_LOOPBACK]   = loopback_r;
    controlView[`PBMC_BIT_SPEED]      = speed100_r;
    controlView[`PBMC_BIT_AN_ENABLE]  = anEnable_r;
    controlView[`PBMC_BIT_POWER_DOWN] = pdEffective;
    controlView[`PBMC_BIT_ISOLATE]    = isolate_r;
    controlView[`PBMC_BIT_DUPLEX]     = fullDuplex_r;
    statusView                        = `PBMC_ZERO16;
    statusView[`PBMC_BIT_LINK_OK]     = linkOk_r;
    statusView[`PBMC_BIT_FAULT]       = fault_r;
    statusView[`PBMC_FIXED_LSB+:4]    = FIXED_CODE;
    statusView[`PBMC_ERRCNT_LSB+:8]   = errCnt_r;
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = !awTaken_r && !s_axi_bvalid;
  assign s_axi_wready  = !wTaken_r && !s_axi_bvalid;
  assign doWrite       = awTaken_r && wTaken_r && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      awTaken_r    <= 1'b0;
      wTaken_r     <= 1'b0;
      awAddr_r     <= 8'h00;
      wData_r      <= `PBMC_ZERO32;
      wStrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PBMC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awTaken_r <= 1'b1;
        awAddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wTaken_r <= 1'b1;
        wData_r  <= s_axi_wdata;
        wStrb_r  <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awTaken_r    <= 1'b0;
        wTaken_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status is read-only: its writes succeed with no effect
        if ((awAddr_r == `PBMC_OFF_CONTROL) || (awAddr_r == `PBMC_OFF_STATUS))
        begin
          s_axi_bresp <= `PBMC_RESP_OKAY;
        end
        else
        begin
          s_axi_bresp <= `PBMC_RESP_SLVERR;
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `PBMC_ZERO32;
      s_axi_rresp  <= `PBMC_RESP_OKAY;
    end
    else if (readTake)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `PBMC_OFF_CONTROL)
      begin
        s_axi_rdata <= {16'h0000, controlView};
        s_axi_rresp <= `PBMC_RESP_OKAY;
      end
      else if (s_axi_araddr == `PBMC_OFF_STATUS)
      begin
        s_axi_rdata <= {16'h0000, statusView};
        s_axi_rresp <= `PBMC_RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= `PBMC_ZERO32;
        s_axi_rresp <= `PBMC_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pbmc_top

/* verif/pbmc_top_monitor.sv */
// Checker of the control bank's bus answers and MAC data gating.
// Assumes it is bound onto pbmc_top and sees only its ports.
`timescale 1ns/10ps
module pbmc_top_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rstn,
  // Bus
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Pins and data
  input wire logic        powerDownRequestPin_n,
  input wire logic        powerDown,
  input wire logic [3:0]  macTxData,
  input wire logic        macTxEn,
  input wire logic [3:0]  macRxData,
  input wire logic        macRxDv,
  input wire logic [3:0]  lineTxData,
  input wire logic        lineTxEn,
  input wire logic [3:0]  lineRxData,
  input wire logic        lineRxDv
);
  // ********
  // Bus answers
  // ********
  a_bvalid_drops: assert property (@(posedge mclk) disable iff (!rstn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
  a_rvalid_drops: assert property (@(posedge mclk) disable iff (!rstn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
  a_upper_half_zero: assert property (@(posedge mclk) disable iff (!rstn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read half not zero");
  a_unmapped_slverr: assert property (@(posedge mclk) disable iff (!rstn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr != 8'h00 && s_axi_araddr != 8'h04
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read answered");
  // ********
  // Data gating
  // ********
  // Pin is synchronised first, so a few cycles of latency are allowed
  a_pin_powers_down: assert property (
    @(posedge mclk) disable iff (!rstn)
    !powerDownRequestPin_n [*5] |-> powerDown) else $error("pin did not power down");
  a_down_is_quiet: assert property (
    @(posedge mclk) disable iff (!rstn)
    powerDown && $past(powerDown) |-> !macRxDv && !lineTxEn) else $error("data moved while down");
  a_tx_from_mac: assert property (
    @(posedge mclk) disable iff (!rstn)
    lineTxEn |-> $past(macTxEn) && lineTxData == $past(macTxData)) else $error("line data not from MAC");
  a_rx_source: assert property (
    @(posedge mclk) disable iff (!rstn)
    macRxDv |-> ($past(lineRxDv) && macRxData == $past(lineRxData))
    || ($past(macTxEn) && macRxData == $past(macTxData))) else $error("receive data from nowhere");
endmodule // pbmc_top_monitor

bind pbmc_top pbmc_top_monitor u_mon (.mclk, .rstn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .powerDownRequestPin_n, .powerDown, .macTxData, .macTxEn, .macRxData, .macRxDv,
  .lineTxData, .lineTxEn, .lineRxData, .lineRxDv);

/* verif/pbmc_top_tb_top.sv */
// Self-checking bench of the control bank: bus, straps, status and data gating.
// Assumes pbmc_top with a short dead time and one 20 MHz clock.
`timescale 1ns/10ps
module pbmc_top_tb_top;
  localparam int DEAD = 16;
  typedef struct packed {
    logic [15:0] wd;
    logic [1:0]  an;
    logic [15:0] rd;
    logic        spd;
    logic        dup;
    logic        dv;
  } pbmc_row_t;
  localparam pbmc_row_t ROWS [7] = '{
    '{16'h0000, 2'h3, 16'h0000, 1'h0, 1'h0, 1'h1}, '{16'h2100, 2'h0, 16'h2100, 1'h1, 1'h1, 1'h1},
    '{16'h2000, 2'h3, 16'h2000, 1'h1, 1'h0, 1'h1}, '{16'h1000, 2'h3, 16'h1000, 1'h1, 1'h1, 1'h1},
    '{16'h3100, 2'h0, 16'h3100, 1'h0, 1'h0, 1'h1}, '{16'h04FF, 2'h0, 16'h0400, 1'h0, 1'h0, 1'h0},
    '{16'h0800, 2'h0, 16'h0800, 1'h0, 1'h0, 1'h0}};
  logic        mclk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, strapAnEnable = 1, strapSpeed100 = 1;
  logic        strapFullDuplex = 1, fiberModeEnable = 0, powerDownRequestPin_n = 1, linkUp = 1;
  logic        faultEvent = 0, rxErrorPulse = 0, anSpeed100 = 0, anFullDuplex = 0, macTxEn = 1;
  logic        lineRxDv = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        macRxDv, lineTxEn, linkSpeed100, linkFullDuplex, powerDown;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 0, macTxData = 4'hA, lineRxData = 4'h6, macRxData, lineTxData;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          failCount = 0, totalChecks = 0, n;

  pbmc_top #(.DEAD_CYCLES(DEAD)) DUT (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .strapAnEnable, .strapSpeed100, .strapFullDuplex, .fiberModeEnable,
    .powerDownRequestPin_n, .linkUp, .faultEvent, .rxErrorPulse, .anSpeed100, .anFullDuplex,
    .macTxData, .macTxEn, .macRxData, .macRxDv, .lineTxData, .lineTxEn, .lineRxData, .lineRxDv,
    .linkSpeed100, .linkFullDuplex, .powerDown);

  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [36:0] got, input logic [36:0] exp, input string msg);
    totalChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end
    while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rdA(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end
    while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic poll();
    int k;
    k = 0;
    do
    begin
      rdA(8'h00);
      k++;
    end
    while (rd[15] !== 1'h0 && k < 40);
  endtask

  initial
  begin
    forever #25 mclk = ~mclk;
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge mclk);
    failCount++;
    endSim();
  end

  // ********
  // Main sequence
  // ********
  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    rdA(8'h00);
    check(rd[15], 1, "reset bit while running");
    poll();
    check(rd, 32'h0000_3100, "strap values");
    rdA(8'h04);
    check(rd, 32'h0000_0050, "status after reset");
    foreach (ROWS[i])
    begin
      @(posedge mclk);
      anSpeed100 <= ROWS[i].an[1];
      anFullDuplex <= ROWS[i].an[0];
      wr(8'h00, {16'h0000, ROWS[i].wd});
      repeat (4) @(posedge mclk);
      rdA(8'h00);
      check(rd, {16'h0000, ROWS[i].rd}, "control readback");
      check({linkSpeed100, linkFullDuplex, powerDown, macRxDv, macRxData, lineTxEn, lineTxData},
        {ROWS[i].spd, ROWS[i].dup, ROWS[i].rd[11], ROWS[i].dv,
        ROWS[i].dv ? {4'h6, 1'h1, 4'hA} : 9'h000}, "modes and data");
    end
    // Link drop and fault are over before the read, so only the latches remember them
    @(posedge mclk);
    linkUp <= 1'h0;
    faultEvent <= 1'h1;
    repeat (3)
    begin
      @(posedge mclk);
      rxErrorPulse <= 1'h1;
      @(posedge mclk);
      rxErrorPulse <= 1'h0;
    end
    linkUp <= 1'h1;
    faultEvent <= 1'h0;
    rdA(8'h04);
    check(rd, 32'h0000_0352, "status events");
    rdA(8'h04);
    check(rd, 32'h0000_0051, "status after read");
    wr(8'h04, 32'h0000_FFFF);
    check(rsp, 2'h0, "status write answer");
    rdA(8'h04);
    check({rsp, rd}, {2'h0, 32'h0000_0051}, "status write");
    rdA(8'h08);
    check({rsp, rd}, {2'h2, 32'h0000_0000}, "unmapped read");
    wr(8'h08, 32'h0000_FFFF);
    check(rsp, 2'h2, "unmapped write");
    @(posedge mclk);
    macTxEn <= 1'h1;
    macTxData <= 4'hA;
    wr(8'h00, 32'h0000_4000);
    n = 0;
    while (macRxDv !== 1'h1 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    check(n >= DEAD - 2 && n <= DEAD + 4, 1, "dead time");
    check({macRxData, lineTxEn}, {4'hA, 1'h0}, "loopback data");
    @(posedge mclk);
    macTxEn <= 1'h0;
    fiberModeEnable <= 1'h1;
    strapSpeed100 <= 1'h0;
    repeat (4) @(posedge mclk);
    wr(8'h00, 32'h0000_C000);
    rdA(8'h00);
    check(rd[15], 1, "software reset running");
    poll();
    repeat (2) @(posedge mclk);
    check({rd, linkSpeed100, linkFullDuplex}, {32'h0000_0100, 2'h1}, "re-strapped");
    @(posedge mclk);
    powerDownRequestPin_n <= 1'h0;
    repeat (8) @(posedge mclk);
    rdA(8'h00);
    check({rd, powerDown}, {32'h0000_0900, 1'h1}, "pin power down");
    endSim();
  end
endmodule // pbmc_top_tb_top
